//--- rtl/conv_sup_pkg.sv
// Shared constants and types of the isolated converter supervisor.
package conv_sup_pkg;

  // --------------------------------------------------------------------------
  // System clock
  // --------------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int SYS_CLK_KHZ = 40000;

  // --------------------------------------------------------------------------
  // Transformer clocking
  // --------------------------------------------------------------------------
  localparam int INT_OSC_KHZ = 8000;
  localparam int INT_DIV_CYC = SYS_CLK_KHZ / INT_OSC_KHZ;
  localparam int INT_HIGH_CYC = 2;
  localparam int SSM_HOLD_PERIODS = 16;
  localparam int EXT_CLK_MHZ = 16;
  localparam int EXT_TOL_PCT = 10;
  localparam int MON_WINDOW_NS = 10000;
  localparam int MON_WINDOW_CYC = MON_WINDOW_NS / CLK_PERIOD_NS;
  localparam int MON_EDGES_MIN = EXT_CLK_MHZ * (100 - EXT_TOL_PCT) * MON_WINDOW_NS / 100000;
  localparam int MON_EDGES_MAX = EXT_CLK_MHZ * (100 + EXT_TOL_PCT) * MON_WINDOW_NS / 100000;

  // --------------------------------------------------------------------------
  // Start-up timing
  // --------------------------------------------------------------------------
  localparam int SEL_WINDOW_US = 1000;
  localparam int SEL_WINDOW_CYC = SEL_WINDOW_US * 1000 / CLK_PERIOD_NS;
  localparam int SEL_SETTLE_US = 10;
  localparam int SEL_SETTLE_CYC = (SEL_SETTLE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SOFT_START_US = 100;
  localparam int SOFT_START_CYC = (SOFT_START_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // --------------------------------------------------------------------------
  // Pin vector positions
  // --------------------------------------------------------------------------
  localparam int PIN_COUNT = 12;
  localparam int IDX_EN = 0;
  localparam int IDX_RISE = 1;
  localparam int IDX_FALL = 2;
  localparam int IDX_FOLD = 3;
  localparam int IDX_RECOVER = 4;
  localparam int IDX_SHORT = 5;
  localparam int IDX_OVERLOAD = 6;
  localparam int IDX_HOT = 7;
  localparam int IDX_COOL = 8;
  localparam int IDX_SEL_OUT = 9;
  localparam int IDX_SEL_RES = 10;
  localparam int IDX_SYNC = 11;

  // --------------------------------------------------------------------------
  // Output level codes and reset values
  // --------------------------------------------------------------------------
  localparam logic [1:0] LEVEL_3V3 = 2'h0;
  localparam logic [1:0] LEVEL_3V7 = 2'h1;
  localparam logic [1:0] LEVEL_5V0 = 2'h2;
  localparam logic [1:0] LEVEL_5V4 = 2'h3;
  localparam logic [1:0] LEVEL_RESET = LEVEL_3V3;
  localparam logic LOCKOUT_RESET = 1'b1;

  typedef enum logic [1:0] {ST_OFF, ST_SOFT_START, ST_RUN} conv_state_t;

endpackage : conv_sup_pkg

//--- rtl/clk_mon_if.sv
// Carrier between the supervisor and its external clock monitor.
`timescale 1ns/1ps
interface clk_mon_if;
  logic sync_level;
  logic sync_rise;
  logic clk_valid;
  modport monitor (input sync_level, output sync_rise, output clk_valid);
  modport user (output sync_level, input sync_rise, input clk_valid);
endinterface : clk_mon_if

//--- rtl/pin_sync.sv
// Three-stage pin synchroniser with a two-stage agreement filter per bit.
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 12
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [WIDTH-1:0] pin_i,
  output logic [WIDTH-1:0] level_o
);

  generate
    if (WIDTH < 1) begin : g_bad_width
      $error("pin_sync needs at least one bit");
    end
  endgenerate

  genvar b;
  generate
    for (b = 0; b < WIDTH; b++) begin : g_bit
      logic s1_reg;
      logic s2_reg;
      logic s3_reg;
      logic level_reg;
      wire agree = (s2_reg == s3_reg);
      // Reset to zero keeps an undriven enable pin in the disabled state.
      always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          s1_reg <= 1'b0;
          s2_reg <= 1'b0;
          s3_reg <= 1'b0;
          level_reg <= 1'b0;
        end else begin
          s1_reg <= pin_i[b];
          s2_reg <= s1_reg;
          s3_reg <= s2_reg;
          level_reg <= agree ? s3_reg : level_reg;
        end
      end
      assign level_o[b] = level_reg;
    end
  endgenerate

endmodule : pin_sync

//--- rtl/ext_clock_monitor.sv
// Frequency window check on the filtered external clock pin.
`timescale 1ns/1ps
module ext_clock_monitor #(
  parameter int WINDOW_CYC = 400,
  parameter int EDGES_MIN = 144,
  parameter int EDGES_MAX = 176
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  clk_mon_if.monitor mon
);

  localparam int CW = $clog2(WINDOW_CYC + 1);

  generate
    if (EDGES_MIN > EDGES_MAX || EDGES_MAX >= WINDOW_CYC || EDGES_MIN < 1) begin : g_bad
      $error("ext_clock_monitor edge bounds do not fit the window");
    end
  endgenerate

  logic prev_reg;
  logic [CW-1:0] win_cnt_reg;
  logic [CW-1:0] edge_cnt_reg;
  logic valid_reg;

  wire rise = mon.sync_level & ~prev_reg;
  wire win_end = (win_cnt_reg == CW'(WINDOW_CYC - 1));
  wire [CW-1:0] edge_total = edge_cnt_reg + CW'(rise);
  wire in_range = (edge_total >= CW'(EDGES_MIN)) && (edge_total <= CW'(EDGES_MAX));
  wire [CW-1:0] win_cnt_next = win_end ? '0 : win_cnt_reg + CW'(1);
  wire [CW-1:0] edge_cnt_next = win_end ? '0 : edge_total;
  // The verdict changes only at a window end, so a lost clock is noticed one window late.
  wire valid_next = win_end ? in_range : valid_reg;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prev_reg <= 1'b0;
      win_cnt_reg <= '0;
      edge_cnt_reg <= '0;
      valid_reg <= 1'b0;
    end else begin
      prev_reg <= mon.sync_level;
      win_cnt_reg <= win_cnt_next;
      edge_cnt_reg <= edge_cnt_next;
      valid_reg <= valid_next;
    end
  end

  assign mon.sync_rise = rise;
  assign mon.clk_valid = valid_reg;

endmodule : ext_clock_monitor

//--- rtl/conv_supervisor.sv
// Enable, lockout, overload, thermal and clock supervision of the converter.
`timescale 1ns/1ps
module conv_supervisor #(
  parameter int SEL_WINDOW_CYC = conv_sup_pkg::SEL_WINDOW_CYC,
  parameter int SYNC_WINDOW_CYC = conv_sup_pkg::MON_WINDOW_CYC,
  parameter int SYNC_EDGES_MIN = conv_sup_pkg::MON_EDGES_MIN,
  parameter int SYNC_EDGES_MAX = conv_sup_pkg::MON_EDGES_MAX
) (
  input wire logic SYS_CLK_I,
  input wire logic RST_N_I,
  input wire logic EN_I,
  input wire logic SUPPLY_ABOVE_RISE_I,
  input wire logic SUPPLY_BELOW_FALL_I,
  input wire logic ISO_BELOW_FOLD_I,
  input wire logic ISO_ABOVE_RECOVER_I,
  input wire logic ISO_BELOW_SHORT_I,
  input wire logic LOAD_OVER_MAX_I,
  input wire logic TEMP_ABOVE_SHUTDOWN_I,
  input wire logic TEMP_BELOW_RESTART_I,
  input wire logic SEL_TO_OUTPUT_I,
  input wire logic SEL_VIA_RESISTOR_I,
  input wire logic SYNC_I,
  output logic XFMR_DRIVE_O,
  output logic CONV_ON_O,
  output logic LOW_POWER_O,
  output logic SOFT_START_O,
  output logic POWER_LIMIT_O,
  output logic ACTIVE_RECT_O,
  output logic THERMAL_SHUTDOWN_O,
  output logic SUPPLY_LOCKOUT_O,
  output logic [1:0] LEVEL_SEL_O,
  output logic SPREAD_SPECTRUM_ON_O,
  output logic EXT_CLK_SEL_O,
  output logic SYNC_OK_O,
  output logic SYNC_OK_OE_O
);

  // --------------------------------------------------------------------------
  // Parameter checks and widths
  // --------------------------------------------------------------------------
  localparam int SW = $clog2(SEL_WINDOW_CYC + 1);
  localparam int SSW = $clog2(conv_sup_pkg::SOFT_START_CYC + 1);
  localparam int OW = $clog2(conv_sup_pkg::INT_DIV_CYC + 2);
  localparam int PW = $clog2(conv_sup_pkg::SSM_HOLD_PERIODS + 1);

  generate
    if (SEL_WINDOW_CYC <= conv_sup_pkg::SEL_SETTLE_CYC) begin : g_bad_window
      $error("select window must be longer than the settle time");
    end
    if (conv_sup_pkg::INT_DIV_CYC < conv_sup_pkg::INT_HIGH_CYC + 2) begin : g_bad_div
      $error("internal divider too short for spread spectrum");
    end
  endgenerate

  // --------------------------------------------------------------------------
  // Pin synchronisation
  // --------------------------------------------------------------------------
  logic [conv_sup_pkg::PIN_COUNT-1:0] pins;
  logic [conv_sup_pkg::PIN_COUNT-1:0] lvl;

  assign pins[conv_sup_pkg::IDX_EN] = EN_I;
  assign pins[conv_sup_pkg::IDX_RISE] = SUPPLY_ABOVE_RISE_I;
  assign pins[conv_sup_pkg::IDX_FALL] = SUPPLY_BELOW_FALL_I;
  assign pins[conv_sup_pkg::IDX_FOLD] = ISO_BELOW_FOLD_I;
  assign pins[conv_sup_pkg::IDX_RECOVER] = ISO_ABOVE_RECOVER_I;
  assign pins[conv_sup_pkg::IDX_SHORT] = ISO_BELOW_SHORT_I;
  assign pins[conv_sup_pkg::IDX_OVERLOAD] = LOAD_OVER_MAX_I;
  assign pins[conv_sup_pkg::IDX_HOT] = TEMP_ABOVE_SHUTDOWN_I;
  assign pins[conv_sup_pkg::IDX_COOL] = TEMP_BELOW_RESTART_I;
  assign pins[conv_sup_pkg::IDX_SEL_OUT] = SEL_TO_OUTPUT_I;
  assign pins[conv_sup_pkg::IDX_SEL_RES] = SEL_VIA_RESISTOR_I;
  assign pins[conv_sup_pkg::IDX_SYNC] = SYNC_I;

  // An undriven enable is caught low by the synchroniser reset value.
  pin_sync #(
    .WIDTH(conv_sup_pkg::PIN_COUNT)
  ) u_pin_sync (
    .clk_i(SYS_CLK_I),
    .rst_n_i(RST_N_I),
    .pin_i(pins),
    .level_o(lvl)
  );

  wire en = lvl[conv_sup_pkg::IDX_EN];
  wire above_rise = lvl[conv_sup_pkg::IDX_RISE];
  wire below_fall = lvl[conv_sup_pkg::IDX_FALL];
  wire below_fold = lvl[conv_sup_pkg::IDX_FOLD];
  wire above_recover = lvl[conv_sup_pkg::IDX_RECOVER];
  wire below_short = lvl[conv_sup_pkg::IDX_SHORT];
  wire overload = lvl[conv_sup_pkg::IDX_OVERLOAD];
  wire hot = lvl[conv_sup_pkg::IDX_HOT];
  wire cool = lvl[conv_sup_pkg::IDX_COOL];
  wire sel_out = lvl[conv_sup_pkg::IDX_SEL_OUT];
  wire sel_res = lvl[conv_sup_pkg::IDX_SEL_RES];

  // --------------------------------------------------------------------------
  // External clock monitor
  // --------------------------------------------------------------------------
  clk_mon_if mon_bus ();

  assign mon_bus.sync_level = lvl[conv_sup_pkg::IDX_SYNC];

  ext_clock_monitor #(
    .WINDOW_CYC(SYNC_WINDOW_CYC),
    .EDGES_MIN(SYNC_EDGES_MIN),
    .EDGES_MAX(SYNC_EDGES_MAX)
  ) u_clk_mon (
    .clk_i(SYS_CLK_I),
    .rst_n_i(RST_N_I),
    .mon(mon_bus.user)
  );

  wire ext_valid = mon_bus.clk_valid;

  // --------------------------------------------------------------------------
  // Lockout, thermal and enable gating
  // --------------------------------------------------------------------------
  logic lockout_reg;
  logic tsd_reg;
  logic en_d_reg;

  // Separate set and clear comparators give the band; holding in between stops chatter.
  wire lockout_next = below_fall ? 1'b1 : (above_rise ? 1'b0 : lockout_reg);
  wire tsd_next = hot ? 1'b1 : (cool ? 1'b0 : tsd_reg);
  wire allow = en & ~lockout_reg & ~tsd_reg;
  wire start_event = (en & ~en_d_reg) | (lockout_reg & ~lockout_next);

  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      lockout_reg <= conv_sup_pkg::LOCKOUT_RESET;
      tsd_reg <= 1'b0;
      en_d_reg <= 1'b0;
    end else begin
      lockout_reg <= lockout_next;
      tsd_reg <= tsd_next;
      en_d_reg <= en;
    end
  end

  // --------------------------------------------------------------------------
  // Output level selection window
  // --------------------------------------------------------------------------
  logic [SW-1:0] sel_cnt_reg;
  logic window_reg;
  logic [1:0] level_reg;

  wire sel_last = (sel_cnt_reg == SW'(SEL_WINDOW_CYC - 1));
  wire sel_take = window_reg & allow & (sel_cnt_reg == SW'(conv_sup_pkg::SEL_SETTLE_CYC - 1));
  wire [SW-1:0] sel_cnt_next = start_event ? '0 : (window_reg ? sel_cnt_reg + SW'(1) : sel_cnt_reg);
  wire window_next = start_event | (window_reg & ~sel_last);
  wire [1:0] level_pick = sel_out
    ? (sel_res ? conv_sup_pkg::LEVEL_5V4 : conv_sup_pkg::LEVEL_5V0)
    : (sel_res ? conv_sup_pkg::LEVEL_3V7 : conv_sup_pkg::LEVEL_3V3);
  // After the window closes the select pin no longer reaches the level.
  wire [1:0] level_next = sel_take ? level_pick : level_reg;

  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      sel_cnt_reg <= '0;
      window_reg <= 1'b0;
      level_reg <= conv_sup_pkg::LEVEL_RESET;
    end else begin
      sel_cnt_reg <= sel_cnt_next;
      window_reg <= window_next;
      level_reg <= level_next;
    end
  end

  // --------------------------------------------------------------------------
  // Converter state machine
  // --------------------------------------------------------------------------
  conv_sup_pkg::conv_state_t state_reg;
  conv_sup_pkg::conv_state_t state_next;
  logic [SSW-1:0] ss_cnt_reg;
  logic [SSW-1:0] ss_cnt_next;

  wire ss_done = (ss_cnt_reg == SSW'(conv_sup_pkg::SOFT_START_CYC - 1));

  always_comb begin
    state_next = state_reg;
    ss_cnt_next = ss_cnt_reg;
    unique case (state_reg)
      conv_sup_pkg::ST_OFF: begin
        ss_cnt_next = '0;
        if (allow) begin
          state_next = conv_sup_pkg::ST_SOFT_START;
        end
      end
      conv_sup_pkg::ST_SOFT_START: begin
        ss_cnt_next = ss_cnt_reg + SSW'(1);
        if (!allow) begin
          state_next = conv_sup_pkg::ST_OFF;
        end else if (ss_done) begin
          state_next = conv_sup_pkg::ST_RUN;
        end
      end
      conv_sup_pkg::ST_RUN: begin
        ss_cnt_next = '0;
        if (!allow) begin
          state_next = conv_sup_pkg::ST_OFF;
        end else if (below_short) begin
          state_next = conv_sup_pkg::ST_SOFT_START;
        end
      end
    endcase
  end

  // --------------------------------------------------------------------------
  // Rectification fold-back and power limit
  // --------------------------------------------------------------------------
  logic active_rect_reg;
  logic power_limit_reg;

  wire run_next = (state_next == conv_sup_pkg::ST_RUN);
  wire power_limit_next = run_next & overload;
  wire active_rect_next = !run_next ? 1'b1
    : ((overload & below_fold) ? 1'b0 : (above_recover ? 1'b1 : active_rect_reg));

  // --------------------------------------------------------------------------
  // Transformer clock generation
  // --------------------------------------------------------------------------
  logic [OW-1:0] osc_cnt_reg;
  logic [PW-1:0] ssm_cnt_reg;
  logic ssm_phase_reg;
  logic drive_reg;

  wire ssm_on = ~ext_valid;
  // Alternating short and long periods keep the mean at the trimmed rate.
  wire [OW-1:0] period = !ssm_on ? OW'(conv_sup_pkg::INT_DIV_CYC)
    : (ssm_phase_reg ? OW'(conv_sup_pkg::INT_DIV_CYC + 1) : OW'(conv_sup_pkg::INT_DIV_CYC - 1));
  wire osc_wrap = (osc_cnt_reg >= period - OW'(1));
  wire [OW-1:0] osc_cnt_next = osc_wrap ? '0 : osc_cnt_reg + OW'(1);
  wire ssm_wrap = osc_wrap & (ssm_cnt_reg == PW'(conv_sup_pkg::SSM_HOLD_PERIODS - 1));
  wire [PW-1:0] ssm_cnt_next = !osc_wrap ? ssm_cnt_reg : (ssm_wrap ? '0 : ssm_cnt_reg + PW'(1));
  wire ssm_phase_next = ssm_wrap ? ~ssm_phase_reg : ssm_phase_reg;
  wire int_drive = (osc_cnt_next < OW'(conv_sup_pkg::INT_HIGH_CYC));
  // Toggling on each qualified rising edge halves the external clock.
  wire ext_drive = mon_bus.sync_rise ? ~drive_reg : drive_reg;
  // Source swap is not glitch-free; one short pulse can occur at the change.
  wire drive_next = (state_next == conv_sup_pkg::ST_OFF) ? 1'b0
    : (ext_valid ? ext_drive : int_drive);

  // --------------------------------------------------------------------------
  // State and output registers
  // --------------------------------------------------------------------------
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      state_reg <= conv_sup_pkg::ST_OFF;
      ss_cnt_reg <= '0;
      active_rect_reg <= 1'b1;
      power_limit_reg <= 1'b0;
      osc_cnt_reg <= '0;
      ssm_cnt_reg <= '0;
      ssm_phase_reg <= 1'b0;
      drive_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      ss_cnt_reg <= ss_cnt_next;
      active_rect_reg <= active_rect_next;
      power_limit_reg <= power_limit_next;
      osc_cnt_reg <= osc_cnt_next;
      ssm_cnt_reg <= ssm_cnt_next;
      ssm_phase_reg <= ssm_phase_next;
      drive_reg <= drive_next;
    end
  end

  logic conv_on_reg;
  logic low_power_reg;
  logic soft_start_reg;
  logic ext_sel_reg;
  logic ssm_out_reg;
  logic sync_ok_oe_reg;

  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      conv_on_reg <= 1'b0;
      low_power_reg <= 1'b1;
      soft_start_reg <= 1'b0;
      ext_sel_reg <= 1'b0;
      ssm_out_reg <= 1'b1;
      sync_ok_oe_reg <= 1'b1;
    end else begin
      conv_on_reg <= (state_next != conv_sup_pkg::ST_OFF);
      low_power_reg <= ~en;
      soft_start_reg <= (state_next == conv_sup_pkg::ST_SOFT_START);
      ext_sel_reg <= ext_valid;
      ssm_out_reg <= ssm_on;
      sync_ok_oe_reg <= ~ext_valid;
    end
  end

  assign XFMR_DRIVE_O = drive_reg;
  assign CONV_ON_O = conv_on_reg;
  assign LOW_POWER_O = low_power_reg;
  assign SOFT_START_O = soft_start_reg;
  assign POWER_LIMIT_O = power_limit_reg;
  assign ACTIVE_RECT_O = active_rect_reg;
  assign THERMAL_SHUTDOWN_O = tsd_reg;
  assign SUPPLY_LOCKOUT_O = lockout_reg;
  assign LEVEL_SEL_O = level_reg;
  assign SPREAD_SPECTRUM_ON_O = ssm_out_reg;
  assign EXT_CLK_SEL_O = ext_sel_reg;
  // The pin is only ever pulled low; the board pull-up makes the high level.
  assign SYNC_OK_O = 1'b0;
  assign SYNC_OK_OE_O = sync_ok_oe_reg;

endmodule : conv_supervisor

//--- sim/conv_sup_sva.sv
// Concurrent checks on the ports of the converter supervisor.
`timescale 1ns/1ps
module conv_sup_sva (
  input wire logic SYS_CLK_I,
  input wire logic RST_N_I,
  input wire logic XFMR_DRIVE_O,
  input wire logic CONV_ON_O,
  input wire logic LOW_POWER_O,
  input wire logic SOFT_START_O,
  input wire logic POWER_LIMIT_O,
  input wire logic ACTIVE_RECT_O,
  input wire logic THERMAL_SHUTDOWN_O,
  input wire logic SUPPLY_LOCKOUT_O,
  input wire logic [1:0] LEVEL_SEL_O,
  input wire logic SPREAD_SPECTRUM_ON_O,
  input wire logic EXT_CLK_SEL_O,
  input wire logic SYNC_OK_O,
  input wire logic SYNC_OK_OE_O
);
  // --------------------------------------------------------------------------
  // Properties
  // --------------------------------------------------------------------------
  // Flags and state may register one edge apart, so two-cycle antecedents are used, three for the drive check.
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!RST_N_I);
  property p_en_off;
    LOW_POWER_O [*2] |-> !CONV_ON_O; endproperty
  a_en_off: assert property (p_en_off) else $error("converter on while disabled");
  property p_lock_off;
    SUPPLY_LOCKOUT_O [*2] |-> !CONV_ON_O; endproperty
  a_lock_off: assert property (p_lock_off) else $error("converter on in lockout");
  property p_hot_off;
    THERMAL_SHUTDOWN_O [*2] |-> !CONV_ON_O; endproperty
  a_hot_off: assert property (p_hot_off) else $error("converter on while hot");
  property p_drive_off;
    !CONV_ON_O [*3] |-> !XFMR_DRIVE_O; endproperty
  a_drive_off: assert property (p_drive_off) else $error("drive active while off");
  property p_plim;
    POWER_LIMIT_O |-> (CONV_ON_O && !SOFT_START_O) || ($past(CONV_ON_O) && !$past(SOFT_START_O));
  endproperty
  a_plim: assert property (p_plim) else $error("power limit outside run");
  property p_rect;
    !ACTIVE_RECT_O |-> (CONV_ON_O && !SOFT_START_O) || ($past(CONV_ON_O) && !$past(SOFT_START_O));
  endproperty
  a_rect: assert property (p_rect) else $error("passive rectification outside run");
  property p_osc;
    XFMR_DRIVE_O && !EXT_CLK_SEL_O |-> ##[1:10] !XFMR_DRIVE_O; endproperty
  a_osc: assert property (p_osc) else $error("internal drive stuck high");
  property p_mode;
    SYNC_OK_OE_O ? (!SYNC_OK_O && !EXT_CLK_SEL_O && SPREAD_SPECTRUM_ON_O)
                 : (EXT_CLK_SEL_O && !SPREAD_SPECTRUM_ON_O); endproperty
  a_mode: assert property (p_mode) else $error("clock mode outputs disagree");
  property p_level;
    $changed(LEVEL_SEL_O) |-> SOFT_START_O; endproperty
  a_level: assert property (p_level) else $error("level changed outside start window");
endmodule : conv_sup_sva

bind conv_supervisor conv_sup_sva u_sva (.SYS_CLK_I(SYS_CLK_I), .RST_N_I(RST_N_I),
  .XFMR_DRIVE_O(XFMR_DRIVE_O), .CONV_ON_O(CONV_ON_O), .LOW_POWER_O(LOW_POWER_O),
  .SOFT_START_O(SOFT_START_O), .POWER_LIMIT_O(POWER_LIMIT_O), .ACTIVE_RECT_O(ACTIVE_RECT_O),
  .THERMAL_SHUTDOWN_O(THERMAL_SHUTDOWN_O), .SUPPLY_LOCKOUT_O(SUPPLY_LOCKOUT_O),
  .LEVEL_SEL_O(LEVEL_SEL_O), .SPREAD_SPECTRUM_ON_O(SPREAD_SPECTRUM_ON_O),
  .EXT_CLK_SEL_O(EXT_CLK_SEL_O), .SYNC_OK_O(SYNC_OK_O), .SYNC_OK_OE_O(SYNC_OK_OE_O));

//--- sim/sys_ctrl_model.sv
// System controller model: select strapping and external clock source.
`timescale 1ns/1ps
module sys_ctrl_model (
  input wire logic clk_i,
  input wire logic [1:0] sel_code_i,
  input wire logic [3:0] half_i,
  output logic sel_to_output_o,
  output logic sel_via_resistor_o,
  output logic sync_o
);
  logic [3:0] cnt_reg = 4'h0;
  logic sync_reg = 1'b0;
  // Select is always strapped one way or the other, never left open.
  assign sel_to_output_o = sel_code_i[1];
  assign sel_via_resistor_o = sel_code_i[0];
  assign sync_o = sync_reg;
  // Clock period is twice half_i cycles; it rests low while stopped.
  always @(negedge clk_i) begin
    if (half_i == 4'h0) begin
      sync_reg <= 1'b0;
      cnt_reg <= 4'h0;
    end else if (cnt_reg + 4'h1 >= half_i) begin
      sync_reg <= !sync_reg;
      cnt_reg <= 4'h0;
    end else begin
      cnt_reg <= cnt_reg + 4'h1;
    end
  end
endmodule : sys_ctrl_model

//--- sim/tb_conv_supervisor.sv
// Self-checking testbench of the converter supervisor.
`timescale 1ns/1ps
module tb_conv_supervisor;
  // --------------------------------------------------------------------------
  // Stimulus, outputs and model state
  // --------------------------------------------------------------------------
  localparam int LIMIT = 40000;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic en = 1'b0;
  logic rise = 1'b1;
  logic fall = 1'b0;
  logic fold = 1'b0;
  logic recov = 1'b0;
  logic short_c = 1'b0;
  logic load = 1'b0;
  logic hot = 1'b0;
  logic cool = 1'b0;
  logic [1:0] code = 2'h0;
  logic [3:0] half = 4'h0;
  logic sel_o, sel_r, sync, xdrv, on, lowp, ss, plim, arect, thr, lock, spread, ext, okv, okoe;
  logic [1:0] lvl;
  logic [1:0] exp_lvl;
  logic prev;
  wire okpin = okoe ? okv : 1'b1;
  int err_count = 0;
  int checked = 0;
  int cyc = 0;
  int n;
  integer seed;

  always #12.5 clk = !clk;

  sys_ctrl_model ctrl (.clk_i(clk), .sel_code_i(code), .half_i(half),
    .sel_to_output_o(sel_o), .sel_via_resistor_o(sel_r), .sync_o(sync));

  conv_supervisor #(.SEL_WINDOW_CYC(500), .SYNC_WINDOW_CYC(400), .SYNC_EDGES_MIN(45),
    .SYNC_EDGES_MAX(55)) uut (.SYS_CLK_I(clk), .RST_N_I(rst_n), .EN_I(en),
    .SUPPLY_ABOVE_RISE_I(rise), .SUPPLY_BELOW_FALL_I(fall), .ISO_BELOW_FOLD_I(fold),
    .ISO_ABOVE_RECOVER_I(recov), .ISO_BELOW_SHORT_I(short_c), .LOAD_OVER_MAX_I(load),
    .TEMP_ABOVE_SHUTDOWN_I(hot), .TEMP_BELOW_RESTART_I(cool), .SEL_TO_OUTPUT_I(sel_o),
    .SEL_VIA_RESISTOR_I(sel_r), .SYNC_I(sync), .XFMR_DRIVE_O(xdrv), .CONV_ON_O(on),
    .LOW_POWER_O(lowp), .SOFT_START_O(ss), .POWER_LIMIT_O(plim), .ACTIVE_RECT_O(arect),
    .THERMAL_SHUTDOWN_O(thr), .SUPPLY_LOCKOUT_O(lock), .LEVEL_SEL_O(lvl),
    .SPREAD_SPECTRUM_ON_O(spread), .EXT_CLK_SEL_O(ext), .SYNC_OK_O(okv), .SYNC_OK_OE_O(okoe));

  // --------------------------------------------------------------------------
  // Tasks and model
  // --------------------------------------------------------------------------
  function automatic logic [1:0] level_of(input logic [1:0] c);
    if (c[1]) return c[0] ? conv_sup_pkg::LEVEL_5V4 : conv_sup_pkg::LEVEL_5V0;
    return c[0] ? conv_sup_pkg::LEVEL_3V7 : conv_sup_pkg::LEVEL_3V3;
  endfunction : level_of

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic tick(input int c);
    repeat (c) @(negedge clk);
  endtask : tick

  // Counts drive transitions over 160 cycles, one full spread spectrum pattern.
  task automatic count_toggles;
    n = 0;
    prev = xdrv;
    repeat (160) begin
      @(negedge clk);
      if (xdrv !== prev) n++;
      prev = xdrv;
    end
  endtask : count_toggles

  task automatic test_done;
    $display("Checks %0d, mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : test_done

  // The limit sits well above the roughly 20000 cycles the sequence needs.
  always @(posedge clk) begin
    cyc++;
    if (cyc == LIMIT) begin
      err_count++;
      test_done;
    end
  end

  // --------------------------------------------------------------------------
  // Sequence
  // --------------------------------------------------------------------------
  initial begin
    seed = 32'hdd51dca0;
    tick(5);
    rst_n = 1'b1;
    chk(8'(lock), 8'h1);
    chk(8'(lowp), 8'h1);
    chk(8'(okpin), 8'h0);
    tick(10);
    chk(8'(on), 8'h0);
    for (int i = 0; i < 4; i++) begin
      code = 2'(i);
      exp_lvl = level_of(code);
      en = 1'b1;
      tick(10);
      chk(8'(ss), 8'h1);
      chk(8'(lowp), 8'h0);
      tick(600);
      chk(8'(lvl), 8'(exp_lvl));
      code = 2'($random(seed));
      tick(3420);
      chk(8'(lvl), 8'(exp_lvl));
      chk(8'(ss), 8'h0);
      if (i < 3) begin
        en = 1'b0;
        tick(8);
        chk(8'(on), 8'h0);
        chk(8'(lowp), 8'h1);
      end
    end
    load = 1'b1;
    fold = 1'b1;
    tick(8);
    chk(8'(plim), 8'h1);
    chk(8'(arect), 8'h0);
    fold = 1'b0;
    tick(8);
    chk(8'(arect), 8'h0);
    recov = 1'b1;
    tick(8);
    chk(8'(arect), 8'h1);
    load = 1'b0;
    recov = 1'b0;
    short_c = 1'b1;
    tick(8);
    chk(8'(ss), 8'h1);
    short_c = 1'b0;
    hot = 1'b1;
    tick(8);
    hot = 1'b0;
    tick(8);
    chk(8'(thr), 8'h1);
    chk(8'(on), 8'h0);
    cool = 1'b1;
    tick(8);
    cool = 1'b0;
    chk(8'(on), 8'h1);
    chk(8'(thr), 8'h0);
    chk(8'(lvl), 8'(exp_lvl));
    fall = 1'b1;
    rise = 1'b0;
    tick(8);
    fall = 1'b0;
    tick(8);
    chk(8'(lock), 8'h1);
    chk(8'(on), 8'h0);
    rise = 1'b1;
    exp_lvl = level_of(code);
    tick(600);
    chk(8'(on), 8'h1);
    chk(8'(lock), 8'h0);
    chk(8'(lvl), 8'(exp_lvl));
    half = 4'h4;
    tick(900);
    chk(8'(okpin), 8'h1);
    chk(8'(spread), 8'h0);
    chk(8'(ext), 8'h1);
    count_toggles;
    chk(8'(n), 8'h14);
    half = 4'h0;
    tick(900);
    chk(8'(okpin), 8'h0);
    half = 4'h3;
    tick(900);
    chk(8'(okpin), 8'h0);
    chk(8'(ext), 8'h0);
    chk(8'(spread), 8'h1);
    count_toggles;
    chk(8'(n), 8'h40);
    test_done;
  end
endmodule : tb_conv_supervisor
